// ---- src/hport_defs.svh ----
`ifndef HPORT_DEFS_SVH
`define HPORT_DEFS_SVH
`define MODE_ASYNC_LATCH 3'h0
`define MODE_ASYNC_ALT 3'h1
`define MODE_SYNC 3'h7
`define SEL_HI 10
`define SEL_LO 8
`define REG_HI 7
`define CASCADE_ID_DEF 3'h0
`define ACK_MAX_NS 150
`define CLK_PERIOD_NS 20
`define ACK_MAX_CYC ((`ACK_MAX_NS) / (`CLK_PERIOD_NS))
`define SYNC_STAGES 2
`endif

// ---- src/hport_pkg.sv ----
package hport_pkg;
	typedef enum logic [2:0] {
		C_IDLE = 3'b001,
		C_DATA = 3'b010,
		C_HOLD = 3'b100
	} cstate_e;
	typedef enum logic [2:0] {
		U_IDLE = 3'b001,
		U_WAIT = 3'b010,
		U_DONE = 3'b100
	} ustate_e;
	typedef struct packed {
		logic [2:0] mode;
		logic cs_n;
		logic ale;
		logic strb_n;
		logic wr_dir;
		logic [10:0] addr;
		logic [7:0] data;
	} pins_s;
	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} req_s;
	typedef struct packed {
		cstate_e st;
		logic [2:0] mode;
		logic mode_ok;
		logic smode;
		logic src_sync;
		logic wr;
		logic oe;
		logic req;
		logic ack_tgl;
		logic ale3;
		logic rq3;
		logic [7:0] hold;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
	} cregs_s;
	typedef struct packed {
		ustate_e st;
		logic ts_prev;
		logic ak3;
		logic [7:0] lat;
		req_s req;
		logic req_tgl;
		logic [7:0] rdata;
		logic oe;
	} uregs_s;
endpackage

// ---- src/host_parallel_register_port.sv ----
// Notes on behaviour
// - async latch mode captures low address byte when the latch strobe falls.
// - sync mode captures low address byte when transfer begin falls.
// - async read strobe low with chip select low starts a read.
// - async store strobe low with chip select low starts a write.
// - cycle_complete_n low marks access finished, in both modes.
// - sync mode direction pin high means read, low means write.
// - sync mode access strobe low with chip select low starts access.
// - sync mode port logic runs on the host bus clock.
// - async read drives data while read strobe and select are low.
// - after read strobe falls, completion goes low once data is valid.
// - async write keeps data drivers off and takes the bus as input.
// - async write stores data, then drives completion low.
// - latch strobe tied high makes the address capture transparent.
// - async completion within 150 ns of the strobe.
// - sync read drives data, completion when valid, host then releases.
// - no output enable pin; drivers follow strobe, direction and select.
// - mode pins 000 async latch, 001 other async, 111 synchronous; the port answers no access in mode 001.
// - accesses are answered only while chip select is low.
// - address bits 10..8 pick the cascaded device, 7..0 the register.
`timescale 1ns/1ps
`include "hport_defs.svh"
`default_nettype none
module host_parallel_register_port #(
	parameter logic [2:0] CASCADE_ID = `CASCADE_ID_DEF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic host_bus_clk,
	input wire logic [2:0] host_mode_pins,
	input wire logic cs_n,
	input wire logic [10:0] addr,
	input wire logic addr_latch_or_xfer_begin_pin,
	input wire logic access_strobe_n,
	input wire logic write_strobe_or_dir,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	output logic cycle_complete_n,
	output logic core_req,
	output logic core_wr,
	output logic [7:0] core_addr,
	output logic [7:0] core_wdata,
	input wire logic [7:0] core_rdata
);
	localparam int ACK_WIN = `ACK_MAX_CYC - `SYNC_STAGES - 1;
	function automatic logic addr_hit(input logic [2:0] sel);
		return sel == CASCADE_ID;
	endfunction

	// pin synchroniser, core clock side
	hport_pkg::pins_s pin_raw;
	hport_pkg::pins_s p1_r;
	hport_pkg::pins_s p2_r;
	assign pin_raw = '{mode: host_mode_pins, cs_n: cs_n,
		ale: addr_latch_or_xfer_begin_pin, strb_n: access_strobe_n,
		wr_dir: write_strobe_or_dir, addr: addr, data: data_in};

	logic rq1_r;
	logic rq2_r;
	hport_pkg::uregs_s u_r;
	hport_pkg::uregs_s u_nxt;
	hport_pkg::cregs_s c_r;
	hport_pkg::cregs_s c_nxt;

	always_ff @(posedge clk) begin
		// pins keep moving in reset so straps are valid at release
		if (ce) begin
			p1_r <= pin_raw;
			p2_r <= p1_r;
		end
		if (rst) begin
			rq1_r <= 1'b0;
			rq2_r <= 1'b0;
		end else if (ce) begin
			rq1_r <= u_r.req_tgl;
			rq2_r <= rq1_r;
		end
	end
	logic async_mode;
	logic rd_go;
	logic wr_go;
	logic a_go;
	logic rq_edge;
	logic [7:0] addr_eff;

	always_comb begin
		async_mode = c_r.mode_ok && (c_r.mode == `MODE_ASYNC_LATCH);
		rd_go = !p2_r.cs_n && !p2_r.strb_n;
		wr_go = !p2_r.cs_n && !p2_r.wr_dir;
		a_go = async_mode && (rd_go || wr_go)
			&& addr_hit(p2_r.addr[`SEL_HI:`SEL_LO]);
		rq_edge = rq2_r ^ c_r.rq3;
		// latch strobe held high: follow the bus directly
		addr_eff = p2_r.ale ? p2_r.addr[`REG_HI:0] : c_r.hold;
	end

	always_comb begin
		c_nxt = c_r;
		c_nxt.req = 1'b0;
		c_nxt.ale3 = p2_r.ale;
		c_nxt.rq3 = rq2_r;
		// straps caught once, first cycle after reset release
		if (!c_r.mode_ok) begin
			c_nxt.mode = p2_r.mode;
			c_nxt.mode_ok = 1'b1;
		end
		c_nxt.smode = c_r.mode_ok && (c_r.mode == `MODE_SYNC);
		if (async_mode && c_r.ale3 && !p2_r.ale) begin
			c_nxt.hold = p2_r.addr[`REG_HI:0];
		end
		unique case (c_r.st)
			hport_pkg::C_IDLE: begin
				if (a_go) begin
					// both strobes low: read wins, nothing is stored
					c_nxt.wr = !rd_go;
					c_nxt.addr = addr_eff;
					c_nxt.wdata = p2_r.data;
					c_nxt.req = 1'b1;
					c_nxt.src_sync = 1'b0;
					c_nxt.oe = rd_go;
					c_nxt.st = hport_pkg::C_DATA;
				end else if (c_r.smode && rq_edge) begin
					// word is stable: held until acknowledged
					c_nxt.wr = u_r.req.wr;
					c_nxt.addr = u_r.req.addr;
					c_nxt.wdata = u_r.req.wdata;
					c_nxt.req = 1'b1;
					c_nxt.src_sync = 1'b1;
					c_nxt.st = hport_pkg::C_DATA;
				end
			end
			hport_pkg::C_DATA: begin
				if (!c_r.wr) begin
					c_nxt.rdata = core_rdata;
				end
				if (c_r.src_sync) begin
					c_nxt.ack_tgl = !c_r.ack_tgl;
					c_nxt.st = hport_pkg::C_IDLE;
				end else begin
					c_nxt.st = hport_pkg::C_HOLD;
				end
			end
			hport_pkg::C_HOLD: begin
				// level wait keeps one access per strobe
				if (p2_r.cs_n || (c_r.wr ? p2_r.wr_dir : p2_r.strb_n)) begin
					c_nxt.oe = 1'b0;
					c_nxt.st = hport_pkg::C_IDLE;
				end
			end
			default: begin
				c_nxt.oe = 1'b0;
				c_nxt.st = hport_pkg::C_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			c_r <= '0;
			c_r.st <= hport_pkg::C_IDLE;
		end else if (ce) begin
			c_r <= c_nxt;
		end
	end
	// host clock side: reset, enable and mode cross as levels
	logic [2:0] us1_r;
	logic [2:0] us2_r;
	logic rst_u;
	logic ce_u;
	logic ak1_r;
	logic ak2_r;

	always_ff @(posedge host_bus_clk) begin
		us1_r <= {rst, ce, c_r.smode};
		us2_r <= us1_r;
	end
	assign rst_u = us2_r[2];
	assign ce_u = us2_r[1];

	always_ff @(posedge host_bus_clk) begin
		if (rst_u) begin
			ak1_r <= 1'b0;
			ak2_r <= 1'b0;
		end else if (ce_u) begin
			ak1_r <= c_r.ack_tgl;
			ak2_r <= ak1_r;
		end
	end

	logic ts_fall;
	logic u_go;
	always_comb begin
		ts_fall = u_r.ts_prev && !addr_latch_or_xfer_begin_pin;
		u_go = us2_r[0] && !cs_n && !access_strobe_n
			&& addr_hit(addr[`SEL_HI:`SEL_LO]);
	end

	always_comb begin
		u_nxt = u_r;
		u_nxt.ts_prev = addr_latch_or_xfer_begin_pin;
		u_nxt.ak3 = ak2_r;
		if (ts_fall) begin
			u_nxt.lat = addr[`REG_HI:0];
		end
		unique case (u_r.st)
			hport_pkg::U_IDLE: begin
				if (u_go) begin
					u_nxt.req.wr = !write_strobe_or_dir;
					// strobe may come in the same edge as the latch
					u_nxt.req.addr = ts_fall ? addr[`REG_HI:0] : u_r.lat;
					u_nxt.req.wdata = data_in;
					u_nxt.req_tgl = !u_r.req_tgl;
					u_nxt.oe = write_strobe_or_dir;
					u_nxt.st = hport_pkg::U_WAIT;
				end
			end
			hport_pkg::U_WAIT: begin
				// a dropped select still waits out the handshake
				if (ak2_r ^ u_r.ak3) begin
					u_nxt.rdata = c_r.rdata;
					u_nxt.st = hport_pkg::U_DONE;
				end
			end
			hport_pkg::U_DONE: begin
				if (cs_n || access_strobe_n) begin
					u_nxt.oe = 1'b0;
					u_nxt.st = hport_pkg::U_IDLE;
				end
			end
			default: begin
				u_nxt.oe = 1'b0;
				u_nxt.st = hport_pkg::U_IDLE;
			end
		endcase
	end
	always_ff @(posedge host_bus_clk) begin
		if (rst_u) begin
			u_r <= '0; // edge memory idles low like the pin
			u_r.st <= hport_pkg::U_IDLE;
		end else if (ce_u) begin
			u_r <= u_nxt;
		end
	end

	// one side is always idle, the mode is static
	assign cycle_complete_n = !((c_r.st == hport_pkg::C_HOLD)
		|| (u_r.st == hport_pkg::U_DONE));
	assign data_oe = c_r.oe || u_r.oe;
	assign data_out = u_r.oe ? u_r.rdata : c_r.rdata;
	assign core_req = c_r.req;
	assign core_wr = c_r.wr;
	assign core_addr = c_r.addr;
	assign core_wdata = c_r.wdata;

	property p_async_ack;
		@(posedge clk) disable iff (rst || !ce)
		(c_r.st == hport_pkg::C_IDLE && a_go)
			|-> ##[1:ACK_WIN] !cycle_complete_n;
	endproperty
	a_async_ack: assert property (p_async_ack) else $error("late ack");
	property p_rd_drive;
		@(posedge clk) disable iff (rst || !ce)
		(c_r.st == hport_pkg::C_HOLD && !c_r.wr)
			|-> data_oe && data_out == c_r.rdata;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read undriven");
	property p_wr_nodrive;
		@(posedge clk) disable iff (rst || !ce)
		(async_mode && c_r.wr && c_r.st != hport_pkg::C_IDLE) |-> !data_oe;
	endproperty
	a_wr_nodrive: assert property (p_wr_nodrive) else $error("write drives");
	property p_release;
		@(posedge clk) disable iff (rst || !ce)
		(c_r.st == hport_pkg::C_HOLD && (p2_r.cs_n
			|| (c_r.wr ? p2_r.wr_dir : p2_r.strb_n)))
			|=> cycle_complete_n && !c_r.oe;
	endproperty
	a_release: assert property (p_release) else $error("no release");
	property p_one_access;
		@(posedge clk) disable iff (rst || !ce)
		c_r.req |=> !c_r.req [*2];
	endproperty
	a_one_access: assert property (p_one_access) else $error("double access");
	property p_ale_latch;
		@(posedge clk) disable iff (rst || !ce)
		(async_mode && c_r.ale3 && !p2_r.ale)
			|=> c_r.hold == $past(p2_r.addr[7:0]);
	endproperty
	a_ale_latch: assert property (p_ale_latch) else $error("addr not held");
	property p_wr_done;
		@(posedge clk) disable iff (rst || !ce)
		(c_r.st == hport_pkg::C_DATA && c_r.wr && !c_r.src_sync)
			|-> c_r.req ##1 !cycle_complete_n;
	endproperty
	a_wr_done: assert property (p_wr_done) else $error("write no ack");
	property p_cs_gate;
		@(posedge clk) disable iff (rst || !ce)
		(async_mode && p2_r.cs_n && c_r.st == hport_pkg::C_IDLE) |=> !c_r.req;
	endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("unselected access");
	property p_ts_latch;
		@(posedge host_bus_clk) disable iff (rst_u || !ce_u)
		ts_fall |=> u_r.lat == $past(addr[7:0]);
	endproperty
	a_ts_latch: assert property (p_ts_latch) else $error("ts addr lost");
	property p_dir;
		@(posedge host_bus_clk) disable iff (rst_u || !ce_u)
		(u_r.st == hport_pkg::U_IDLE && u_go)
			|=> u_r.req.wr == !$past(write_strobe_or_dir);
	endproperty
	a_dir: assert property (p_dir) else $error("wrong direction");
	property p_sync_rd;
		@(posedge host_bus_clk) disable iff (rst_u || !ce_u)
		(u_r.st == hport_pkg::U_DONE && !u_r.req.wr)
			|-> data_oe && !cycle_complete_n;
	endproperty
	a_sync_rd: assert property (p_sync_rd) else $error("sync read bad");
	c_async_rd: cover property (@(posedge clk)
		c_r.st == hport_pkg::C_HOLD && !c_r.wr);
	c_async_wr: cover property (@(posedge clk)
		c_r.st == hport_pkg::C_HOLD && c_r.wr);
	c_sync_rd: cover property (@(posedge host_bus_clk)
		u_r.st == hport_pkg::U_DONE && !u_r.req.wr);
	c_sync_wr: cover property (@(posedge host_bus_clk)
		u_r.st == hport_pkg::U_DONE && u_r.req.wr);
endmodule
`default_nettype wire

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk,
	input wire logic host_bus_clk,
	output logic cs_n,
	output logic [10:0] addr,
	output logic latch_pin,
	output logic strb_n,
	output logic wr_dir,
	output logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic cycle_complete_n
);
	initial begin
		cs_n = 1'b1;
		addr = 11'h000;
		latch_pin = 1'b0;
		strb_n = 1'b1;
		wr_dir = 1'b1;
		data_in = 8'h00;
	end
	task automatic tick(input logic sm);
		if (sm) @(posedge host_bus_clk);
		else @(posedge clk);
	endtask
	// sm: sync mode; wr: write; tie: latch pin stays high
	task automatic acc(input logic sm, input logic wr, input logic tie,
		input logic [10:0] a, input logic [7:0] d, output logic acked,
		output logic [7:0] q, output logic oe, output int lat,
		output logic rel);
		acked = 1'b0;
		q = 8'h00;
		oe = 1'b0;
		lat = 0;
		rel = 1'b0;
		tick(sm);
		addr <= a;
		cs_n <= 1'b0;
		latch_pin <= 1'b1;
		data_in <= d;
		if (sm) wr_dir <= !wr;
		tick(sm);
		latch_pin <= tie;
		tick(sm);
		tick(sm);
		// bus moves on, so only the latched byte can be right
		if (!tie) addr <= {a[10:8], ~a[7:0]};
		if (!sm && wr) wr_dir <= 1'b0;
		else strb_n <= 1'b0;
		for (int n = 0; n < 20; n++) begin
			tick(sm);
			lat = n + 1;
			if (cycle_complete_n === 1'b0) begin
				acked = 1'b1;
				q = data_out;
				oe = data_oe;
				break;
			end
		end
		strb_n <= 1'b1;
		if (!sm) wr_dir <= 1'b1;
		data_in <= ~d;
		for (int n = 0; n < 10; n++) begin
			tick(sm);
			if (cycle_complete_n === 1'b1 && data_oe === 1'b0) begin
				rel = 1'b1;
				break;
			end
		end
		cs_n <= 1'b1;
		latch_pin <= 1'b0;
		tick(sm);
	endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic hclk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] mode = 3'h0;
	logic cs_n, lp, strb_n, wr_dir, oe, ccn, core_req, core_wr, last_wr;
	logic [10:0] addr;
	logic [7:0] din, dout, core_addr, core_wdata, core_rdata;
	logic [7:0] last_addr, last_wdata;
	int error_cnt = 0;
	int n_tests = 0;
	int n_req = 0;
	always #10 clk = ~clk;
	// host clock offset so the two domains drift against each other
	initial begin
		#3;
		forever #6 hclk = ~hclk;
	end
	assign core_rdata = core_addr ^ 8'hA5;
	always @(posedge clk) begin
		if (core_req === 1'b1) begin
			n_req <= n_req + 1;
			last_wr <= core_wr;
			last_addr <= core_addr;
			last_wdata <= core_wdata;
		end
	end
	host_parallel_register_port i_host_parallel_register_port (
		.clk(clk), .rst(rst), .ce(1'b1), .host_bus_clk(hclk),
		.host_mode_pins(mode), .cs_n(cs_n), .addr(addr),
		.addr_latch_or_xfer_begin_pin(lp), .access_strobe_n(strb_n),
		.write_strobe_or_dir(wr_dir), .data_in(din), .data_out(dout),
		.data_oe(oe), .cycle_complete_n(ccn), .core_req(core_req),
		.core_wr(core_wr), .core_addr(core_addr),
		.core_wdata(core_wdata), .core_rdata(core_rdata)
	);
	host_model i_host_model (
		.clk(clk), .host_bus_clk(hclk), .cs_n(cs_n), .addr(addr),
		.latch_pin(lp), .strb_n(strb_n), .wr_dir(wr_dir), .data_in(din),
		.data_out(dout), .data_oe(oe), .cycle_complete_n(ccn)
	);
	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (!ok) begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic do_reset(input logic [2:0] m);
		@(posedge clk);
		rst <= 1'b1;
		mode <= m;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		// straps cross two flops in each domain before use
		repeat (6) @(posedge clk);
	endtask
	task automatic run(input logic sm, input logic wr, input logic tie,
		input logic ex, input logic [10:0] a, input logic [7:0] d,
		input string name);
		logic ak, o, r;
		logic [7:0] q;
		int lat, n0;
		n0 = n_req;
		i_host_model.acc(sm, wr, tie, a, d, ak, q, o, lat, r);
		chk(ak === ex, "completion presence");
		chk(r === 1'b1, "no release after strobe");
		if (ex) begin
			chk(lat <= (sm ? 15 : 7), "completion late");
			chk(o === !wr, "driver enable at completion");
			chk(n_req == n0 + 1, "access count");
			chk(last_wr === wr, "direction");
			chk(last_addr === a[7:0], "register index");
			if (wr) chk(last_wdata === d, "write byte");
			else chk(q === (a[7:0] ^ 8'hA5), "read byte");
		end
		else chk(n_req == n0, "refused access reached core");
		// a completion that differs from ex, or no release, ends the run here
		if (ak !== ex || r !== 1'b1) test_done();
		else $display("test %s done", name);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic async_read;
		run(0, 0, 0, 1, 11'h023, 8'h00, "async read");
	endtask
	task automatic async_write;
		run(0, 1, 0, 1, 11'h0C4, 8'h5A, "async write");
	endtask
	task automatic tied_read;
		run(0, 0, 1, 1, 11'h0FF, 8'h00, "latch tied high");
	endtask
	task automatic tied_write;
		run(0, 1, 1, 1, 11'h000, 8'hFF, "tied write");
	endtask
	task automatic cascade_miss;
		run(0, 0, 0, 0, 11'h123, 8'h00, "cascade miss");
	endtask
	task automatic silent_mode;
		run(0, 0, 0, 0, 11'h010, 8'h00, "mode 001 silent");
	endtask
	task automatic sync_read;
		run(1, 0, 0, 1, 11'h055, 8'h00, "sync read");
	endtask
	task automatic sync_write;
		run(1, 1, 0, 1, 11'h0AA, 8'h3C, "sync write");
	endtask
	task automatic sync_miss;
		run(1, 0, 0, 0, 11'h7AA, 8'h00, "sync miss");
	endtask
	initial begin
		do_reset(3'h0);
		async_read();
		async_write();
		tied_read();
		tied_write();
		cascade_miss();
		do_reset(3'h1);
		silent_mode();
		do_reset(3'h7);
		sync_read();
		sync_write();
		sync_miss();
		test_done();
	end
endmodule
`default_nettype wire
